// ### rsc_pkg.sv
// Purpose: Shared constants and types for the reset source controller
// Assumes: 200 MHz mclk, AXI4-Lite register access with 32-bit data
// Notes:   All offsets are byte addresses of aligned words
package rsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus shape
    localparam int          AXI_AW         = 8;
    localparam int          AXI_DW         = 32;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFS_CAUSE   = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_STATUS  = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_CONTROL = 8'h08;

    // Cause flag field positions and reset value
    localparam int          FLAG_W         = 4;
    localparam int          BIT_SUPPLY     = 0;
    localparam int          BIT_PIN        = 1;
    localparam int          BIT_BROWNOUT   = 2;
    localparam int          BIT_WATCHDOG   = 3;
    localparam logic [FLAG_W-1:0] FLAGS_AT_POWERUP = 4'h1;

    // Status field positions
    localparam int          ST_BIT_HOLD    = 0;
    localparam int          ST_BIT_STATE   = 1;
    localparam int          ST_BIT_BO_EN   = 3;
    localparam int          ST_BIT_BG_EN   = 4;
    localparam int          ST_BIT_BG_OK   = 5;

    // Control field positions
    localparam int          CT_BIT_CMP_BG  = 0;

    // Brown-out trigger select codes
    localparam logic [2:0]  BO_SEL_OFF     = 3'h0;
    localparam logic [2:0]  BO_SEL_LVL_A   = 3'h7;
    localparam logic [2:0]  BO_SEL_LVL_B   = 3'h3;
    localparam logic [2:0]  BO_SEL_LVL_C   = 3'h2;
    localparam logic [2:0]  BO_SEL_LVL_D   = 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_PERIOD_PS     = 5000;
    localparam int          BO_MIN_PULSE_NS   = 2000;
    localparam int          PIN_MIN_PULSE_NS  = 100;
    localparam int          BG_STARTUP_US     = 40;
    // Least times round up to whole cycles
    localparam int          BO_MIN_CYC  = (BO_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          PIN_MIN_CYC = (PIN_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          BG_START_CYC = (BG_STARTUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          STRETCH_BASE_CYC = 1024;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        ST_HOLD    = 2'h0,
        ST_STRETCH = 2'h1,
        ST_RUN     = 2'h3
    } rsc_state_e;

    typedef struct packed {
        logic                 awvalid;
        logic [AXI_AW-1:0]    awaddr;
        logic                 wvalid;
        logic [AXI_DW-1:0]    wdata;
        logic [AXI_DW/8-1:0]  wstrb;
        logic                 bready;
        logic                 arvalid;
        logic [AXI_AW-1:0]    araddr;
        logic                 rready;
    } rsc_axi_req_s;

    typedef struct packed {
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [AXI_DW-1:0]    rdata;
        logic [1:0]           rresp;
    } rsc_axi_rsp_s;

endpackage : rsc_pkg

// ### rsc_reset_controller.sv
// Purpose: Combines four reset sources, stretches the release, records the cause
// Assumes: All inputs synchronous to mclk; supply detector acts only on an mclk edge too
// Notes:   Pin pulse without a clock is caught only once mclk runs
`timescale 1ns/1ps

// How it works
// - Supply, pin, watchdog and brown-out sources all hold the core reset.
// - Pin low longer than minimum width forces reset; short pulses ignored.
// - Supply below threshold asserts reset at once, again on every fall.
// - Supply rising above threshold starts the stretch counter before release.
// - Pin returning high starts the stretch counter; release after time-out.
// - Enabled brown-out asserts reset after the minimum width; release after stretch time-out.
// - Brown-out dips shorter than the minimum detection width are ignored.
// - Trigger select 000 disables detector; four codes enable; rest reserved.
// - Watchdog expiry resets only while the watchdog is enabled.
// - Watchdog reset is a one-cycle pulse; stretch starts as it falls.
// - Watchdog flag set by watchdog reset; cleared by supply reset or write-zero.
// - Brown-out flag set by brown-out reset; cleared by supply reset or write-zero.
// - Pin flag set by pin reset; cleared by supply reset or write-zero.
// - Supply flag set by supply reset; cleared only by software write-zero.
// - Bandgap on when brown-out, comparator select, converter or DAC enabled.
// - Any active reset source clears the comparator select bit of the control register.
// - Stretch length picked by start-up and clock-source settings; then vector start.
module rsc_reset_controller #(
    parameter int CNT_W       = 24,
    parameter int STRETCH_CYC = rsc_pkg::STRETCH_BASE_CYC,
    parameter int BO_CYC      = rsc_pkg::BO_MIN_CYC,
    parameter int PIN_CYC     = rsc_pkg::PIN_MIN_CYC,
    parameter int BG_CYC      = rsc_pkg::BG_START_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic                  ce,
    input  wire logic                  supply_below,
    input  wire logic                  reset_pin_n,
    input  wire logic                  wdt_expire,
    input  wire logic                  wdt_enable,
    input  wire logic                  brownout_below,
    input  wire logic [2:0]            brownout_trigger_select,
    input  wire logic [1:0]            startup_time_setting,
    input  wire logic                  clock_source_setting,
    input  wire logic                  converter_enable,
    input  wire logic                  dac_enable,
    input  wire rsc_pkg::rsc_axi_req_s axi_req,
    output rsc_pkg::rsc_axi_rsp_s      axi_rsp,
    output logic                       core_reset,
    output logic                       start_at_vector,
    output logic                       brownout_detector_enable,
    output logic                       bandgap_enable
);
    import rsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    rsc_state_e         state, next_state;
    logic [CNT_W-1:0]   stretch_cnt, next_stretch_cnt;
    logic [CNT_W-1:0]   pin_cnt, next_pin_cnt;
    logic [CNT_W-1:0]   bo_cnt, next_bo_cnt;
    logic [CNT_W-1:0]   bg_cnt, next_bg_cnt;
    logic               pin_active, next_pin_active;
    logic               bo_active, next_bo_active;
    logic               wdt_pulse, next_wdt_pulse;
    logic               next_core_reset, next_start_at_vector;
    logic               next_bo_det_en, next_bandgap_enable;
    logic [FLAG_W-1:0]  cause_flags, next_cause_flags;
    logic               cmp_bg_sel, next_cmp_bg_sel;
    logic               aw_held, next_aw_held;
    logic               w_held, next_w_held;
    logic [AXI_AW-1:0]  wr_addr, next_wr_addr;
    logic [AXI_DW-1:0]  wr_data, next_wr_data;
    logic [AXI_DW/8-1:0] wr_strb, next_wr_strb;
    rsc_axi_rsp_s       next_axi_rsp;

    logic               bo_enabled;
    logic               any_source;
    logic [2:0]         stretch_shift;
    logic [CNT_W-1:0]   stretch_load;
    logic               do_write;
    logic [AXI_DW-1:0]  rd_word;
    logic               rd_hit;

    ////////////////////////////////////////////////////////////////////////
    // Source qualification
    // Reserved select codes are treated as disabled, never as a guess
    always_comb begin
        bo_enabled = (brownout_trigger_select == BO_SEL_LVL_A) ||
                     (brownout_trigger_select == BO_SEL_LVL_B) ||
                     (brownout_trigger_select == BO_SEL_LVL_C) ||
                     (brownout_trigger_select == BO_SEL_LVL_D);
    end

    // Width filters: a source counts only after its low has lasted
    always_comb begin
        next_pin_cnt    = '0;
        next_pin_active = 1'b0;
        if (!reset_pin_n) begin
            next_pin_cnt    = pin_cnt;
            next_pin_active = pin_active;
            if (pin_cnt == CNT_W'(PIN_CYC)) begin
                next_pin_active = 1'b1;
            end else begin
                next_pin_cnt = pin_cnt + CNT_W'(1);
            end
        end
        next_bo_cnt    = '0;
        next_bo_active = 1'b0;
        if (bo_enabled && brownout_below) begin
            next_bo_cnt    = bo_cnt;
            next_bo_active = bo_active;
            if (bo_cnt == CNT_W'(BO_CYC)) begin
                next_bo_active = 1'b1;
            end else begin
                next_bo_cnt = bo_cnt + CNT_W'(1);
            end
        end
        next_wdt_pulse = wdt_expire && wdt_enable && !wdt_pulse;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencing
    // Shift grows the stretch with slower start-up and clock choices
    always_comb begin
        stretch_shift = {clock_source_setting, startup_time_setting};
        stretch_load  = CNT_W'(STRETCH_CYC) << stretch_shift;
        any_source    = supply_below || pin_active || bo_active || wdt_pulse;
    end

    always_comb begin
        next_state           = state;
        next_stretch_cnt     = stretch_cnt;
        next_start_at_vector = 1'b0;
        case (state)
            ST_HOLD: begin
                // Leaves hold once the last source is gone, incl. pulse fall
                if (!any_source) begin
                    next_state       = ST_STRETCH;
                    next_stretch_cnt = stretch_load;
                end
            end
            ST_STRETCH: begin
                if (any_source) begin
                    next_state = ST_HOLD;
                end else if (stretch_cnt == '0) begin
                    next_state           = ST_RUN;
                    next_start_at_vector = 1'b1;
                end else begin
                    next_stretch_cnt = stretch_cnt - CNT_W'(1);
                end
            end
            ST_RUN: begin
                if (any_source) begin
                    next_state = ST_HOLD;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
        // Core held from the next edge after a source appears, no waiting on state
        next_core_reset = any_source || (next_state != ST_RUN);
    end

    ////////////////////////////////////////////////////////////////////////
    // Bandgap reference request
    always_comb begin
        next_bo_det_en      = bo_enabled;
        next_bandgap_enable = bo_enabled || cmp_bg_sel ||
                              converter_enable || dac_enable;
        // Settle counter lets software see when analog results are usable
        next_bg_cnt = '0;
        if (bandgap_enable) begin
            next_bg_cnt = (bg_cnt == CNT_W'(BG_CYC)) ? bg_cnt : bg_cnt + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        if (axi_req.araddr == OFS_CAUSE) begin
            rd_word[FLAG_W-1:0] = cause_flags;
        end else if (axi_req.araddr == OFS_STATUS) begin
            rd_word[ST_BIT_HOLD]           = core_reset;
            rd_word[ST_BIT_STATE +: 2]     = state;
            rd_word[ST_BIT_BO_EN]          = brownout_detector_enable;
            rd_word[ST_BIT_BG_EN]          = bandgap_enable;
            rd_word[ST_BIT_BG_OK]          = (bg_cnt == CNT_W'(BG_CYC));
        end else if (axi_req.araddr == OFS_CONTROL) begin
            rd_word[CT_BIT_CMP_BG]         = cmp_bg_sel;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Address and data are taken in either order, write runs once both held
    always_comb begin
        next_axi_rsp = axi_rsp;
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        do_write     = aw_held && w_held && !axi_rsp.bvalid;
        if (axi_rsp.awready && axi_req.awvalid) begin
            next_aw_held = 1'b1;
            next_wr_addr = axi_req.awaddr;
        end
        if (axi_rsp.wready && axi_req.wvalid) begin
            next_w_held  = 1'b1;
            next_wr_data = axi_req.wdata;
            next_wr_strb = axi_req.wstrb;
        end
        if (axi_rsp.bvalid && axi_req.bready) begin
            next_axi_rsp.bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held        = 1'b0;
            next_w_held         = 1'b0;
            next_axi_rsp.bvalid = 1'b1;
            next_axi_rsp.bresp  = ((wr_addr == OFS_CAUSE) || (wr_addr == OFS_STATUS) ||
                                   (wr_addr == OFS_CONTROL)) ? RESP_OKAY : RESP_SLVERR;
        end
        next_axi_rsp.awready = !next_aw_held && !next_axi_rsp.bvalid;
        next_axi_rsp.wready  = !next_w_held && !next_axi_rsp.bvalid;
        if (axi_rsp.rvalid && axi_req.rready) begin
            next_axi_rsp.rvalid = 1'b0;
        end
        if (axi_rsp.arready && axi_req.arvalid) begin
            next_axi_rsp.rvalid = 1'b1;
            next_axi_rsp.rdata  = rd_word;
            next_axi_rsp.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        next_axi_rsp.arready = !next_axi_rsp.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // Cause flags and control register
    // Hardware set wins over a software clear landing in the same cycle
    always_comb begin
        next_cause_flags = cause_flags;
        next_cmp_bg_sel  = cmp_bg_sel;
        if (do_write && (wr_addr == OFS_CAUSE) && wr_strb[0]) begin
            next_cause_flags = cause_flags & wr_data[FLAG_W-1:0];
        end
        if (do_write && (wr_addr == OFS_CONTROL) && wr_strb[0]) begin
            next_cmp_bg_sel = wr_data[CT_BIT_CMP_BG];
        end
        if (supply_below) begin
            next_cause_flags = FLAGS_AT_POWERUP;
        end else begin
            // Flags accumulate until software clears them
            next_cause_flags[BIT_PIN]      = next_cause_flags[BIT_PIN] | pin_active;
            next_cause_flags[BIT_BROWNOUT] = next_cause_flags[BIT_BROWNOUT] | bo_active;
            next_cause_flags[BIT_WATCHDOG] = next_cause_flags[BIT_WATCHDOG] | wdt_pulse;
        end
        if (any_source) begin
            next_cmp_bg_sel = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state                    <= ST_HOLD;
            stretch_cnt              <= '0;
            pin_cnt                  <= '0;
            bo_cnt                   <= '0;
            bg_cnt                   <= '0;
            pin_active               <= 1'b0;
            bo_active                <= 1'b0;
            wdt_pulse                <= 1'b0;
            core_reset               <= 1'b1;
            start_at_vector          <= 1'b0;
            brownout_detector_enable <= 1'b0;
            bandgap_enable           <= 1'b0;
            cause_flags              <= FLAGS_AT_POWERUP;
            cmp_bg_sel               <= 1'b0;
            aw_held                  <= 1'b0;
            w_held                   <= 1'b0;
            wr_addr                  <= '0;
            wr_data                  <= '0;
            wr_strb                  <= '0;
            axi_rsp                  <= '0;
        end else if (ce) begin
            state                    <= next_state;
            stretch_cnt              <= next_stretch_cnt;
            pin_cnt                  <= next_pin_cnt;
            bo_cnt                   <= next_bo_cnt;
            bg_cnt                   <= next_bg_cnt;
            pin_active               <= next_pin_active;
            bo_active                <= next_bo_active;
            wdt_pulse                <= next_wdt_pulse;
            core_reset               <= next_core_reset;
            start_at_vector          <= next_start_at_vector;
            brownout_detector_enable <= next_bo_det_en;
            bandgap_enable           <= next_bandgap_enable;
            cause_flags              <= next_cause_flags;
            cmp_bg_sel               <= next_cmp_bg_sel;
            aw_held                  <= next_aw_held;
            w_held                   <= next_w_held;
            wr_addr                  <= next_wr_addr;
            wr_data                  <= next_wr_data;
            wr_strb                  <= next_wr_strb;
            axi_rsp                  <= next_axi_rsp;
        end
    end

endmodule : rsc_reset_controller

// ### rsc_reset_controller_props.sv
// Purpose: Port-level temporal checks for the reset source controller
// Assumes: One mclk domain, ce held high
// Notes:   Counters saturate, so very long runs stay safe
`timescale 1ns/1ps
module rsc_reset_controller_chk
    import rsc_pkg::*;
#(
    parameter int STRETCH_CYC = STRETCH_BASE_CYC,
    parameter int BO_CYC      = BO_MIN_CYC,
    parameter int PIN_CYC     = PIN_MIN_CYC
) (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic       supply_below,
    input wire logic       reset_pin_n,
    input wire logic       wdt_expire,
    input wire logic       wdt_enable,
    input wire logic       brownout_below,
    input wire logic [1:0] startup_time_setting,
    input wire logic       clock_source_setting,
    input wire logic [2:0] brownout_trigger_select,
    input wire logic       converter_enable,
    input wire logic       dac_enable,
    input wire logic       core_reset,
    input wire logic       start_at_vector,
    input wire logic       brownout_detector_enable,
    input wire logic       bandgap_enable
);
    logic [15:0] quiet, pin_cnt, bo_cnt, next_quiet, next_pin, next_bo, lim;
    logic        src_on, cause;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    // Quiet time counts any raw source, so it never overstates the stretch
    always_comb begin
        src_on     = supply_below | ~reset_pin_n | brownout_below | wdt_expire;
        cause      = supply_below | ~reset_pin_n | (brownout_below & brownout_detector_enable) | (wdt_expire & wdt_enable);
        lim        = 16'(STRETCH_CYC << {clock_source_setting, startup_time_setting});
        next_quiet = (!reset_n || src_on) ? '0 : quiet + 16'(quiet != '1);
        next_pin   = reset_pin_n ? '0 : pin_cnt + 16'(pin_cnt != '1);
        next_bo    = (brownout_below && brownout_detector_enable) ? bo_cnt + 16'(bo_cnt != '1) : '0;
    end
    always_ff @(posedge mclk) begin
        quiet   <= next_quiet;
        pin_cnt <= next_pin;
        bo_cnt  <= next_bo;
    end
    ////////////////////////////////////////////////////////////////////////
    a_supply_now: assert property (supply_below |=> core_reset)
        else $error("supply low without core reset");
    a_pin_long: assert property (pin_cnt >= 16'(PIN_CYC + 3) |-> core_reset)
        else $error("long pin low without core reset");
    a_bo_long: assert property (bo_cnt >= 16'(BO_CYC + 3) |-> core_reset)
        else $error("long brown-out without core reset");
    a_bo_code: assert property ($past(reset_n) |->
        brownout_detector_enable == ($past(brownout_trigger_select) inside {3'h7, 3'h3, 3'h2, 3'h1}))
        else $error("detector enable wrong for code");
    a_bg_follow: assert property ($past(reset_n) && $past(converter_enable || dac_enable) |-> bandgap_enable)
        else $error("bandgap off with analog user on");
    a_rise_cause: assert property ($rose(core_reset) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("core reset rose without a cause");
    a_stretch_min: assert property ($fell(core_reset) |-> quiet >= lim)
        else $error("core reset released early");
    a_release_late: assert property (quiet == lim + 16'd8 |-> !core_reset)
        else $error("core reset held too long");
    a_vector_pulse: assert property (start_at_vector |-> $fell(core_reset) ##1 !start_at_vector)
        else $error("vector start not a release pulse");
    c_release: cover property ($fell(core_reset));
    c_wdt: cover property (wdt_expire && wdt_enable);
    c_long: cover property (start_at_vector && clock_source_setting);
endmodule : rsc_reset_controller_chk

bind rsc_reset_controller rsc_reset_controller_chk #(
    .STRETCH_CYC(STRETCH_CYC), .BO_CYC(BO_CYC), .PIN_CYC(PIN_CYC)) chk (.*);

// ### rsc_far_model.sv
// Purpose: Supply monitors, reset pin and watchdog timer seen by the block
// Assumes: src bits 0 supply, 1 pin, 2 brown-out, 3 watchdog
// Notes:   Supply starts low, as at real power-up
`timescale 1ns/1ps
module rsc_far_model (
    input  wire logic       mclk,
    input  wire logic [3:0] src,
    output logic            supply_below,
    output logic            reset_pin_n,
    output logic            brownout_below,
    output logic            wdt_expire
);
    logic wdt_prev;
    // Power-up levels before the first edge
    initial begin
        supply_below = 1'b1;
        reset_pin_n = 1'b1;
        brownout_below = 1'b0;
        wdt_expire = 1'b0;
        wdt_prev = 1'b0;
    end
    // Levels follow requests; time-out gives one pulse per request
    always @(posedge mclk) begin
        supply_below <= src[0];
        reset_pin_n <= ~src[1];
        brownout_below <= src[2];
        wdt_expire <= src[3] & ~wdt_prev;
        wdt_prev <= src[3];
    end
endmodule : rsc_far_model

// ### tb_top.sv
// Purpose: Register and reset-source tests of the reset source controller
// Assumes: Short stretch, pin and brown-out counts via parameters
// Notes:   ce is held high throughout
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import rsc_pkg::*;
    logic         mclk, reset_n, ce, wdt_enable, conv_en, dac_en, clk_src;
    logic [1:0]   su_set;
    logic [2:0]   bo_sel;
    logic [3:0]   src;
    logic         sup, pin_n, wdt_x, bo, core_reset, bde, bg, sav;
    logic [31:0]  rd;
    rsc_axi_req_s req;
    rsc_axi_rsp_s rsp;
    int           err_count, cmp_count, cyc, n;
    rsc_far_model far (.mclk(mclk), .src(src), .supply_below(sup), .reset_pin_n(pin_n),
        .brownout_below(bo), .wdt_expire(wdt_x));
    rsc_reset_controller #(.STRETCH_CYC(4), .BO_CYC(5), .PIN_CYC(3), .BG_CYC(10)) dut (.mclk(mclk),
        .reset_n(reset_n), .ce(ce), .supply_below(sup), .reset_pin_n(pin_n), .wdt_expire(wdt_x),
        .wdt_enable(wdt_enable), .brownout_below(bo), .brownout_trigger_select(bo_sel),
        .startup_time_setting(su_set), .clock_source_setting(clk_src), .converter_enable(conv_en),
        .dac_enable(dac_en), .axi_req(req), .axi_rsp(rsp), .core_reset(core_reset),
        .start_at_vector(sav), .brownout_detector_enable(bde), .bandgap_enable(bg));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    // Write with both channels offered together; bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        `CHK("bresp", er, rsp.bresp)
        @(posedge mclk);
    endtask : wr
    // Waits as long as the slave needs; only the hang guard ends a stuck wait
    task automatic rdr(input logic [7:0] a, input logic [1:0] er);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        req.rready <= 1'b0;
        `CHK("rresp", er, rsp.rresp)
        @(posedge mclk);
    endtask : rdr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rdr(a, RESP_OKAY);
        `CHK("rdata", e, rd)
    endtask : rchk
    // Wait for release of the core reset; a stuck reset runs into the hang guard
    task automatic wrel;
        n = 0;
        while (core_reset !== 1'b0) begin
            @(posedge mclk);
            n++;
        end
    endtask : wrel
    task automatic hit(input int b, input int len, input logic exp_rst);
        src[b] <= 1'b1;
        repeat (len) @(posedge mclk);
        src[b] <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK("core_reset", exp_rst, core_reset)
        wrel();
        if (exp_rst) `CHK("vector", 1'b1, sav)
    endtask : hit
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        {reset_n, wdt_enable, conv_en, dac_en, clk_src, su_set, bo_sel, src} = '0;
        ce = 1'b1;
        req = '0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        wrel();
        rchk(OFS_CAUSE, 32'h1);
        rchk(OFS_STATUS, 32'h6);
        wr(OFS_CAUSE, 32'h0, RESP_OKAY);
        rchk(OFS_CAUSE, 32'h0);
        rdr(8'h0c, RESP_SLVERR);
        `CHK("unmapped", 32'h0, rd)
        wr(8'h0c, 32'h1, RESP_SLVERR);
        $display("power-up test done");
        hit(1, 2, 1'b0);
        hit(1, 8, 1'b1);
        rchk(OFS_CAUSE, 32'h2);
        $display("pin test done");
        for (int c = 0; c < 8; c++) begin
            bo_sel <= c[2:0];
            repeat (3) @(posedge mclk);
            `CHK("bo_en", c inside {1, 2, 3, 7}, bde)
            `CHK("bandgap", c inside {1, 2, 3, 7}, bg)
        end
        hit(2, 3, 1'b0);
        hit(2, 10, 1'b1);
        rchk(OFS_CAUSE, 32'h6);
        bo_sel <= 3'h0;
        hit(2, 10, 1'b0);
        $display("brown-out test done");
        hit(3, 1, 1'b0);
        wdt_enable <= 1'b1;
        hit(3, 1, 1'b1);
        wdt_enable <= 1'b0;
        rchk(OFS_CAUSE, 32'he);
        wr(OFS_CAUSE, 32'hffff_fff8, RESP_OKAY);
        rchk(OFS_CAUSE, 32'h8);
        hit(0, 3, 1'b1);
        rchk(OFS_CAUSE, 32'h1);
        $display("watchdog and supply test done");
        wr(OFS_CONTROL, 32'h1, RESP_OKAY);
        rchk(OFS_CONTROL, 32'h1);
        `CHK("bandgap", 1'b1, bg)
        hit(1, 8, 1'b1);
        rchk(OFS_CONTROL, 32'h0);
        dac_en <= 1'b1;
        repeat (20) @(posedge mclk);
        rdr(OFS_STATUS, RESP_OKAY);
        `CHK("bg_settled", 2'h3, rd[5:4])
        dac_en <= 1'b0;
        conv_en <= 1'b1;
        clk_src <= 1'b1;
        su_set <= 2'h3;
        hit(1, 8, 1'b1);
        `CHK("stretch", 1'b1, n >= 500)
        conv_en <= 1'b0;
        $display("bandgap and stretch test done");
        test_done();
    end
endmodule : tb_top
